/* hdl/flash_host_regs.svh */
// Timing and width constants for the parallel flash host controller
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// ==================================================
// Clock
`define FH_CLK_PERIOD_NS   8

// ==================================================
// Bus and counter widths
`define FH_DATA_W          16
`define FH_ADDR_W_MAX      26
`define FH_CNT_W           8

// ==================================================
// Pin timing, nanoseconds unless noted
`define FH_T_SETUP_NS      10
`define FH_T_PULSE_NS      35
`define FH_T_ACC_NS        100
`define FH_T_HOLD_NS       10
`define FH_T_RP_NS         200
`define FH_T_BUSY_NS       90
`define FH_T_POR_US        300

`endif

/* hdl/flash_host_pkg.sv */
// Types and helpers shared by the flash host controller
package flash_host_pkg;

   // ==================================================
   // Bus sequencer states
   typedef enum logic [5:0]
   {
      ST_IDLE  = 6'h01,
      ST_SETUP = 6'h02,
      ST_READ  = 6'h04,
      ST_WRITE = 6'h08,
      ST_HOLD  = 6'h10,
      ST_RESET = 6'h20
   } bus_state_t;

   // ==================================================
   // Least time to whole cycles, never below one
   function automatic int cycles_up(input int time_ns, input int period_ns);
      int c;
      c = (time_ns + period_ns - 1) / period_ns;
      return (c < 1) ? 1 : c;
   endfunction : cycles_up

endpackage : flash_host_pkg

/* hdl/flash_busy_valid.sv */
// Validity window and level of the shared ready/busy line
`timescale 1ns/1ns
`include "flash_host_regs.svh"

module flash_busy_valid
#(
   parameter int POR_CYC     = 37500,
   parameter int RESTART_CYC = 12
)
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic resetn,
   // Line and restart events
   input  wire logic ready_busy_line,
   input  wire logic restart,
   // Result
   output logic      line_valid,
   output logic      line_ready
);

   logic [15:0] blank;

   // ==================================================
   // Blanking counter
   // Reset value is a constant, so the power-on wait needs no port
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         blank <= 16'(POR_CYC);
      else if (restart)
         blank <= 16'(RESTART_CYC);
      else if (blank != 16'h0000)
         blank <= blank - 16'h0001;
   end

   assign line_valid = (blank == 16'h0000);
   assign line_ready = line_valid & ready_busy_line;

endmodule : flash_busy_valid

/* hdl/flash_host_ctrl.sv */
// Host-side pin sequencer for an asynchronous x16 parallel NOR flash
`timescale 1ns/1ns
`include "flash_host_regs.svh"

module flash_host_ctrl
#(
   parameter int ADDR_W  = `FH_ADDR_W_MAX,
   parameter int POR_CYC = (`FH_T_POR_US * 1000) / `FH_CLK_PERIOD_NS
)
(
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  resetn,
   // User request
   input  wire logic                  req_valid,
   output logic                       req_ready,
   input  wire logic                  req_write,
   input  wire logic [ADDR_W-1:0]     req_addr,
   input  wire logic [`FH_DATA_W-1:0] req_wdata,
   input  wire logic                  ignore_busy,
   input  wire logic                  reset_req,
   input  wire logic                  wp_enable,
   // User answer and status
   output logic                       rsp_valid,
   output logic [`FH_DATA_W-1:0]      rsp_rdata,
   output logic                       flash_ready,
   output logic                       flash_busy_valid,
   // Flash pins
   output logic                       flash_reset_n,
   output logic                       flash_ce_n,
   output logic                       flash_oe_n,
   output logic                       flash_we_n,
   output logic                       flash_wp_n,
   output logic [ADDR_W-1:0]          word_address_bus,
   input  wire logic [`FH_DATA_W-1:0] data_bus_in,
   output logic [`FH_DATA_W-1:0]      data_bus_out,
   output logic                       data_bus_oe,
   input  wire logic                  ready_busy_line
);

   // ==================================================
   // Cycle counts
   localparam logic [`FH_CNT_W-1:0] SETUP_CYC =
      `FH_CNT_W'(flash_host_pkg::cycles_up(`FH_T_SETUP_NS, `FH_CLK_PERIOD_NS));
   localparam logic [`FH_CNT_W-1:0] PULSE_CYC =
      `FH_CNT_W'(flash_host_pkg::cycles_up(`FH_T_PULSE_NS, `FH_CLK_PERIOD_NS));
   localparam logic [`FH_CNT_W-1:0] ACC_CYC =
      `FH_CNT_W'(flash_host_pkg::cycles_up(`FH_T_ACC_NS, `FH_CLK_PERIOD_NS));
   localparam logic [`FH_CNT_W-1:0] HOLD_CYC =
      `FH_CNT_W'(flash_host_pkg::cycles_up(`FH_T_HOLD_NS, `FH_CLK_PERIOD_NS));
   localparam logic [`FH_CNT_W-1:0] RP_CYC =
      `FH_CNT_W'(flash_host_pkg::cycles_up(`FH_T_RP_NS, `FH_CLK_PERIOD_NS));
   localparam int BUSY_CYC = flash_host_pkg::cycles_up(`FH_T_BUSY_NS, `FH_CLK_PERIOD_NS);
   localparam logic [`FH_CNT_W-1:0] ONE = `FH_CNT_W'(1);

   // ==================================================
   // State
   flash_host_pkg::bus_state_t state;
   flash_host_pkg::bus_state_t next_state;
   logic [`FH_CNT_W-1:0]       count;
   logic [`FH_CNT_W-1:0]       next_count;
   logic                       op_write;
   logic                       line_valid;
   logic                       line_ready;

   // ==================================================
   // Decode
   wire done       = (count == `FH_CNT_W'(0));
   wire is_idle    = (state == flash_host_pkg::ST_IDLE);
   // Recovery writes may go while a failed device holds the line low
   wire start_ok   = line_ready | (ignore_busy & req_write);
   wire start      = req_valid & req_ready;
   wire next_op    = start ? req_write : op_write;
   wire next_sel   = (next_state == flash_host_pkg::ST_SETUP) |
                     (next_state == flash_host_pkg::ST_READ)  |
                     (next_state == flash_host_pkg::ST_WRITE) |
                     (next_state == flash_host_pkg::ST_HOLD);
   wire next_ce_n  = ~next_sel;
   wire next_oe_n  = (next_state != flash_host_pkg::ST_READ);
   wire next_we_n  = (next_state != flash_host_pkg::ST_WRITE);
   wire next_rst_n = (next_state != flash_host_pkg::ST_RESET);
   wire next_d_oe  = next_sel & next_op;
   // Busy line is blind right after a write edge or a reset assertion
   wire restart    = (next_we_n & ~flash_we_n) |
                     (~next_rst_n & flash_reset_n);
   wire capture    = (state == flash_host_pkg::ST_READ) & done;

   assign req_ready        = is_idle & ~reset_req & start_ok;
   assign flash_ready      = line_ready;
   assign flash_busy_valid = line_valid;

   // ==================================================
   // Sequencer
   always_comb
   begin
      next_state = state;
      next_count = done ? count : count - ONE;
      case (state)
         flash_host_pkg::ST_IDLE:
         begin
            if (reset_req)
            begin
               next_state = flash_host_pkg::ST_RESET;
               next_count = RP_CYC - ONE;
            end
            else if (start)
            begin
               next_state = flash_host_pkg::ST_SETUP;
               next_count = SETUP_CYC - ONE;
            end
         end
         flash_host_pkg::ST_SETUP:
         begin
            if (done)
            begin
               next_state = op_write ? flash_host_pkg::ST_WRITE : flash_host_pkg::ST_READ;
               next_count = (op_write ? PULSE_CYC : ACC_CYC) - ONE;
            end
         end
         flash_host_pkg::ST_READ,
         flash_host_pkg::ST_WRITE:
         begin
            if (done)
            begin
               next_state = flash_host_pkg::ST_HOLD;
               next_count = HOLD_CYC - ONE;
            end
         end
         flash_host_pkg::ST_HOLD,
         flash_host_pkg::ST_RESET:
         begin
            if (done)
               next_state = flash_host_pkg::ST_IDLE;
         end
         default:
         begin
            next_state = flash_host_pkg::ST_IDLE;
            next_count = `FH_CNT_W'(0);
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= flash_host_pkg::ST_IDLE;
         count <= `FH_CNT_W'(0);
      end
      else
      begin
         state <= next_state;
         count <= next_count;
      end
   end

   // ==================================================
   // Pins, all from flip-flops
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         flash_ce_n    <= 1'h1;
         flash_oe_n    <= 1'h1;
         flash_we_n    <= 1'h1;
         flash_reset_n <= 1'h1;
         data_bus_oe   <= 1'h0;
         flash_wp_n    <= 1'h1;
      end
      else
      begin
         flash_ce_n    <= next_ce_n;
         flash_oe_n    <= next_oe_n;
         flash_we_n    <= next_we_n;
         flash_reset_n <= next_rst_n;
         data_bus_oe   <= next_d_oe;
         flash_wp_n    <= ~wp_enable;
      end
   end

   // Address and data latched once per access so they stay put under the strobes
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         op_write         <= 1'h0;
         word_address_bus <= '0;
         data_bus_out     <= '0;
      end
      else if (start)
      begin
         op_write         <= req_write;
         word_address_bus <= req_addr;
         data_bus_out     <= req_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rsp_valid <= 1'h0;
         rsp_rdata <= '0;
      end
      else
      begin
         rsp_valid <= capture;
         if (capture)
            rsp_rdata <= data_bus_in;
      end
   end

   // ==================================================
   // Ready/busy validity
   flash_busy_valid
   #(
      .POR_CYC     (POR_CYC),
      .RESTART_CYC (BUSY_CYC)
   )
   u_busy_valid
   (
      .core_clk        (core_clk),
      .resetn          (resetn),
      .ready_busy_line (ready_busy_line),
      .restart         (restart),
      .line_valid      (line_valid),
      .line_ready      (line_ready)
   );

   // ==================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   a_strobe_needs_select: assert property (
      (!flash_oe_n || !flash_we_n) |-> !flash_ce_n)
      else $error("strobe active while chip select high");
   a_no_strobe_overlap: assert property (
      !(!flash_oe_n && !flash_we_n))
      else $error("output enable and write enable low together");
   a_write_drives_data: assert property (
      !flash_we_n |-> data_bus_oe && flash_oe_n)
      else $error("write strobe without host data drive");
   a_write_pulse_width: assert property (
      $fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n)
      else $error("write pulse width wrong");
   a_read_no_drive: assert property (
      !flash_oe_n |-> !data_bus_oe ##0 $stable(data_bus_oe))
      else $error("host drives data during read");
   a_addr_stable: assert property (
      (!flash_ce_n && !$past(flash_ce_n)) |-> $stable(word_address_bus) && $stable(data_bus_out))
      else $error("address or data moved during access");
   a_busy_blind_edge: assert property (
      $rose(flash_we_n) |-> !flash_busy_valid [*8])
      else $error("busy line trusted too soon after write");
   a_start_when_ready: assert property (
      (start && !req_write) |-> flash_ready ##1 !flash_ce_n [*2])
      else $error("read started while device busy");
   a_recovery_write: assert property (
      (start && !flash_ready) |-> ignore_busy && req_write)
      else $error("command while busy without recovery");

   c_read:  cover property (!flash_oe_n ##[1:30] rsp_valid);
   c_write: cover property ($fell(flash_we_n) ##[1:20] $rose(flash_we_n));
   c_reset: cover property ($fell(flash_reset_n) ##[1:40] $rose(flash_reset_n));
   c_recov: cover property (start && !flash_ready && ignore_busy);

endmodule : flash_host_ctrl

/* sim/flash_dev_model.sv */
// Behavioural model of the parallel flash seen from its pins
`timescale 1ns/1ns

module flash_dev_model
#(
   parameter int ADDR_W   = 23,
   parameter int BUSY_CYC = 30
)
(
   // Clock used to sample the write strobe and to time the internal algorithm
   input  wire logic              core_clk,
   // Host pins
   input  wire logic              reset_n,
   input  wire logic              ce_n,
   input  wire logic              oe_n,
   input  wire logic              we_n,
   input  wire logic              wp_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [15:0]       data_in,
   // Device outputs
   output logic [15:0]            data_out,
   output logic                   data_oe,
   output logic                   rb_low
);
   // ==================================================
   // Array and algorithm state
   logic [15:0] mem [int];
   // Power-on state: the host never pulses reset before its first access
   int          busy_cnt = 4;
   logic        failed   = 1'b0;
   logic        we_q     = 1'b1;
   logic        wp_eff;

   assign wp_eff = (wp_n === 1'b0) ? 1'b0 : 1'b1;
   assign data_oe = reset_n & ~ce_n & ~oe_n;
   assign rb_low = ~reset_n | (busy_cnt > 0) | failed;

   // Array writes do not wake a star list, so the output strobe does
   always @(addr or oe_n)
      data_out = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hffff;

   // A write ends on the rising write edge; a reset aborts it all
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         busy_cnt <= 4;
         failed <= 1'b0;
         we_q <= 1'b1;
      end
      else
      begin
         we_q <= we_n;
         if (busy_cnt > 0)
            busy_cnt <= busy_cnt - 1;
         if (!we_q && we_n && !ce_n)
         begin
            if (data_in == 16'h00f0)
               failed <= 1'b0;
            else if (!wp_eff && addr < 65536)
               failed <= 1'b1;
            else
            begin
               mem[int'(addr)] = data_in;
               busy_cnt <= BUSY_CYC;
            end
         end
      end
   end
endmodule : flash_dev_model

/* sim/flash_host_pins_ready_busy_test.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ns

module flash_host_pins_ready_busy_test;
   logic        core_clk, resetn, req_valid, req_write, ignore_busy, reset_req, wp_enable;
   logic        req_ready, rsp_valid, flash_ready, flash_reset_n, flash_ce_n, flash_oe_n;
   logic        flash_we_n, flash_wp_n, data_bus_oe, dev_oe, rb_low, ready_busy_line, busy_valid;
   logic [22:0] req_addr, word_address_bus;
   logic [15:0] req_wdata, rsp_rdata, data_bus_out, data_bus_in, dev_out, bus_last, rd;
   logic [15:0] shadow [int];
   logic [22:0] addrs [6];
   int          errors, comparisons, seed, k;

   // ==================================================
   // Wires: pull-up on ready/busy, floating data shows a changing value
   assign ready_busy_line = rb_low ? 1'b0 : 1'b1;
   assign data_bus_in = data_bus_oe ? data_bus_out : (dev_oe ? dev_out : ~bus_last);
   always @(posedge core_clk)
      bus_last <= data_bus_in;

   flash_host_ctrl #(.ADDR_W(23), .POR_CYC(20)) flash_host_ctrl_inst (
      .core_clk(core_clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .ignore_busy(ignore_busy), .reset_req(reset_req), .wp_enable(wp_enable),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .flash_ready(flash_ready),
      .flash_busy_valid(busy_valid), .flash_reset_n(flash_reset_n), .flash_ce_n(flash_ce_n),
      .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_wp_n(flash_wp_n),
      .word_address_bus(word_address_bus), .data_bus_in(data_bus_in),
      .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
      .ready_busy_line(ready_busy_line));

   flash_dev_model #(.ADDR_W(23)) flash_dev_model_inst (
      .core_clk(core_clk), .reset_n(flash_reset_n), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
      .we_n(flash_we_n), .wp_n(flash_wp_n), .addr(word_address_bus),
      .data_in(data_bus_in), .data_out(dev_out), .data_oe(dev_oe), .rb_low(rb_low));

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // ==================================================
   // Comparisons and closing
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_word

   task automatic check_bit(input logic got, input logic exp);
      check_word({15'h0, got}, {15'h0, exp});
   endtask : check_bit

   task automatic stop_test;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   function automatic logic [15:0] expect_word(input logic [22:0] a);
      return shadow.exists(int'(a)) ? shadow[int'(a)] : 16'hffff;
   endfunction : expect_word

   // Lowest 64-kword sector refuses writes while write protect is on
   function automatic logic guarded(input logic [22:0] a);
      return wp_enable && (a < 23'h010000);
   endfunction : guarded

   // Strobes only while selected, never both at once
   always @(negedge core_clk)
      if (resetn && (!flash_oe_n || !flash_we_n))
      begin
         check_bit(flash_ce_n, 1'b0);
         check_bit(flash_oe_n | flash_we_n, 1'b1);
      end

   // ==================================================
   // Bus tasks, all bounded
   task automatic wait_ready;
      k = 0;
      while (flash_ready !== 1'b1 && k < 400)
      begin
         @(negedge core_clk);
         k++;
      end
      if (k >= 400)
      begin
         errors++;
         stop_test();
      end
   endtask : wait_ready

   task automatic access(input logic wr, input logic ib, input logic [22:0] a,
                         input logic [15:0] d);
      req_valid = 1'b1;
      req_write = wr;
      ignore_busy = ib;
      req_addr = a;
      req_wdata = d;
      k = 0;
      while (req_ready !== 1'b1 && k < 400)
      begin
         @(negedge core_clk);
         k++;
      end
      if (k >= 400)
      begin
         errors++;
         stop_test();
      end
      @(negedge core_clk);
      req_valid = 1'b0;
      ignore_busy = 1'b0;
      if (!wr)
      begin
         k = 0;
         do
         begin
            @(posedge core_clk);
            #1;
            k++;
         end
         while (rsp_valid !== 1'b1 && k < 40);
         // Two setup cycles plus thirteen strobe cycles to the response
         check_word(k[15:0], 16'h000f);
         rd = rsp_rdata;
         @(negedge core_clk);
      end
      else if (d != 16'h00f0 && !guarded(a))
         shadow[int'(a)] = d;
   endtask : access

   // ==================================================
   // Main sequence
   initial
   begin
      seed = 32'h03db;
      {resetn, req_valid, req_write, ignore_busy, reset_req, wp_enable} = 6'h0;
      req_addr = 23'h0;
      req_wdata = 16'h0;
      bus_last = 16'h0;
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      resetn = 1'b1;
      check_bit(flash_reset_n & flash_ce_n & flash_we_n & flash_oe_n, 1'b1);
      check_bit(data_bus_oe, 1'b0);
      check_bit(flash_ready, 1'b0);
      check_bit(busy_valid, 1'b0);
      wait_ready();
      $display("test reset done");
      // Sector boundary and top word first, then random upper words
      addrs[0] = 23'h010000;
      addrs[1] = 23'h7fffff;
      for (int i = 2; i < 6; i++)
         addrs[i] = {1'b1, 22'($random(seed))};
      foreach (addrs[i])
         access(1'b1, 1'b0, addrs[i], 16'($random(seed)) | 16'h0100);
      foreach (addrs[i])
      begin
         access(1'b0, 1'b0, addrs[i], 16'h0);
         check_word(rd, expect_word(addrs[i]));
      end
      $display("test write read done");
      // Protected sector: failure holds busy until cleared
      @(negedge core_clk);
      wp_enable = 1'b1;
      wait_ready();
      access(1'b1, 1'b0, 23'h000123, 16'h5a5a);
      repeat (40) @(negedge core_clk);
      check_bit(flash_wp_n, 1'b0);
      check_bit(flash_ready, 1'b0);
      check_bit(busy_valid, 1'b1);
      access(1'b1, 1'b1, 23'h0, 16'h00f0);
      wait_ready();
      access(1'b0, 1'b0, 23'h000123, 16'h0);
      check_word(rd, expect_word(23'h000123));
      $display("test protect done");
      // Second failure cleared by a reset pulse
      access(1'b1, 1'b0, 23'h00ffff, 16'h1234);
      repeat (40) @(negedge core_clk);
      reset_req = 1'b1;
      k = 0;
      while (flash_reset_n !== 1'b0 && k < 50)
      begin
         @(negedge core_clk);
         k++;
      end
      if (k >= 50)
      begin
         errors++;
         stop_test();
      end
      reset_req = 1'b0;
      check_bit(ready_busy_line, 1'b0);
      k = 0;
      while (flash_reset_n === 1'b0 && k < 100)
      begin
         @(negedge core_clk);
         k++;
      end
      check_word(k[15:0], 16'h0019);
      wait_ready();
      check_bit(ready_busy_line, 1'b1);
      $display("test reset pulse done");
      // Unprotected boundary sector accepts writes again
      wp_enable = 1'b0;
      access(1'b1, 1'b0, 23'h00ffff, 16'h3c3c);
      access(1'b0, 1'b0, 23'h00ffff, 16'h0);
      check_word(rd, expect_word(23'h00ffff));
      $display("test unprotect done");
      stop_test();
   end
endmodule : flash_host_pins_ready_busy_test
